// ### pkg/vic_regs.vh
// constants for the vectored interrupt controller
// assumes: included by bare name from every design file of the block
`ifndef VIC_REGS_VH
`define VIC_REGS_VH

// source counts and widths
`define VIC_NUM_TRAP 8
`define VIC_NUM_IRQ 118
`define VIC_NUM_VEC 126
`define VIC_VEC_W 7
`define VIC_LVL_W 4
`define VIC_PRIO_W 3
`define VIC_ADDR_W 24
`define VIC_TRAP_IDX_W 3

// table layout, in program memory word addresses
`define VIC_PRI_BASE 24'h000000
`define VIC_FIRST_OFS 24'h000004
`define VIC_RESET_ADDR 24'h000000
`define VIC_IRQ_VEC0 7'h08
`define VIC_VEC_NONE 7'h00
`define VIC_ADDR_PAD 16'h0000

// levels: 0 is off, 1..7 user, traps sit above every user level
`define VIC_LVL_OFF 4'h0
`define VIC_TRAP_LVL_TOP 15
`define VIC_LVL_PAD 1'b0

// fixed latencies in clock cycles
`define VIC_ENTRY_CYC 4'h5
`define VIC_RETURN_CYC 4'h3
`define VIC_CNT_W 4
`define VIC_CNT_ZERO 4'h0
`define VIC_CNT_ONE 4'h1

// sequencer states
`define VIC_ST_W 3
`define VIC_ST_IDLE 3'h0
`define VIC_ST_FETCH 3'h1
`define VIC_ST_LOAD 3'h2
`define VIC_ST_ENTRY 3'h3
`define VIC_ST_SERVICE 3'h4
`define VIC_ST_RETURN 3'h5

`define VIC_TRAP_ONE 8'h01
`define VIC_TRAP_NONE 8'h00

`endif

// ### hdl/vic_arbiter.v
// priority resolver: per-entry effective level, then highest level, lowest vector
// assumes: request, enable and priority inputs are stable levels on mclk_i
`timescale 1ns/1ns
`include "vic_regs.vh"

module vic_arbiter (
  // sources
  input wire [`VIC_NUM_IRQ-1:0] irq_req_i,
  input wire [`VIC_NUM_IRQ-1:0] irq_en_i,
  input wire [`VIC_NUM_IRQ*`VIC_PRIO_W-1:0] irq_prio_i,
  input wire [`VIC_NUM_TRAP-1:0] trap_pend_i,
  // winner
  output wire win_valid_o,
  output reg [`VIC_VEC_W-1:0] win_vec_o,
  output reg [`VIC_LVL_W-1:0] win_lvl_o
);

  wire [`VIC_NUM_VEC*`VIC_LVL_W-1:0] lvl_flat;
  integer i;

  genvar g;
  generate
    for (g = 0; g < `VIC_NUM_VEC; g = g + 1) begin : g_ent
      if (g < `VIC_NUM_TRAP) begin : g_trap
        // traps ignore enables and rank by table position
        // work the level out as an integer, then keep only the level field
        localparam integer TRAP_LVL_N = `VIC_TRAP_LVL_TOP - g;
        localparam [`VIC_LVL_W-1:0] TRAP_LVL = TRAP_LVL_N[`VIC_LVL_W-1:0];
        assign lvl_flat[g*`VIC_LVL_W +: `VIC_LVL_W] = trap_pend_i[g] ? TRAP_LVL : `VIC_LVL_OFF;
      end else begin : g_irq
        // level 0 keeps a source out of arbitration
        assign lvl_flat[g*`VIC_LVL_W +: `VIC_LVL_W] =
          (irq_req_i[g-`VIC_NUM_TRAP] & irq_en_i[g-`VIC_NUM_TRAP]) ?
          {`VIC_LVL_PAD, irq_prio_i[(g-`VIC_NUM_TRAP)*`VIC_PRIO_W +: `VIC_PRIO_W]} : `VIC_LVL_OFF;
      end
    end
  endgenerate

  // scan downward with >= so the lowest vector wins a tie, fixed order
  always @* begin
    win_lvl_o = `VIC_LVL_OFF;
    win_vec_o = `VIC_VEC_NONE;
    for (i = `VIC_NUM_VEC - 1; i >= 0; i = i - 1) begin
      if (lvl_flat[i*`VIC_LVL_W +: `VIC_LVL_W] != `VIC_LVL_OFF &&
          lvl_flat[i*`VIC_LVL_W +: `VIC_LVL_W] >= win_lvl_o) begin
        win_lvl_o = lvl_flat[i*`VIC_LVL_W +: `VIC_LVL_W];
        win_vec_o = i[`VIC_VEC_W-1:0];
      end
    end
  end

  assign win_valid_o = (win_lvl_o != `VIC_LVL_OFF);

endmodule

// ### hdl/vic_vec_addr.v
// vector entry address: table base plus 4 plus two per vector
// assumes: boot page base is a program memory word address
`timescale 1ns/1ns
`include "vic_regs.vh"

module vic_vec_addr (
  // selection
  input wire [`VIC_VEC_W-1:0] vec_i,
  input wire alt_sel_i,
  input wire boot_seg_present_i,
  input wire [`VIC_ADDR_W-1:0] boot_page_base_i,
  // result
  output wire use_alt_o,
  output wire [`VIC_ADDR_W-1:0] entry_addr_o
);

  wire [`VIC_ADDR_W-1:0] base;

  // without a boot segment there is no alternate table to fall back on
  assign use_alt_o = alt_sel_i & boot_seg_present_i;
  assign base = use_alt_o ? boot_page_base_i : `VIC_PRI_BASE;
  // one word pair per vector, same layout in both tables
  assign entry_addr_o = base + `VIC_FIRST_OFS + {`VIC_ADDR_PAD, vec_i, 1'b0};

endmodule

// ### hdl/vic_top.v
// vectored interrupt controller: merges sources, presents one request,
// fetches the 24-bit handler address from the selected table
// assumes: the core answers a request with core_accept_i, returns program
// memory data one cycle after pm_rd_o, and pulses core_return_i on return
`timescale 1ns/1ns
`include "vic_regs.vh"

// Operation
// - all peripheral requests merge into one request to the core
// - sources take one of seven user levels, zero keeps them out
// - equal level ties go to the lower vector, vector 0 first
// - order within one level is fixed, never rotating
// - primary table starts at word address 000004h
// - table holds 126 entries, eight traps then 118 interrupts
// - each entry yields a 24-bit handler address loaded by the core
// - every source owns its own distinct vector entry
// - traps rank oscillator, address, hardware, stack, math, reserved, software, reserved
// - interrupt vector 0 at 000014h, two apart, vector 116 at 0000FCh
// - traps cannot be masked by enables
// - alternate select makes every interrupt and trap use the alternate table
// - alternate table mirrors primary layout, 04h, 14h through FEh
// - alternate table base is the last boot segment page start
// - alternate table exists only with a boot segment present
// - entry and return latencies are fixed cycle counts
// - device reset bypasses the controller, execution starts at 000000h
module vic_top (
  // clock and reset
  input wire mclk_i,
  input wire srst_i,
  // peripheral sources
  input wire [`VIC_NUM_IRQ-1:0] irq_req_i,
  input wire [`VIC_NUM_IRQ-1:0] irq_en_i,
  input wire [`VIC_NUM_IRQ*`VIC_PRIO_W-1:0] irq_prio_i,
  input wire [`VIC_NUM_TRAP-1:0] trap_i,
  // table selection
  input wire alt_table_select_i,
  input wire boot_seg_present_i,
  input wire [`VIC_ADDR_W-1:0] boot_page_base_i,
  // core side
  input wire [`VIC_LVL_W-1:0] cpu_level_i,
  input wire core_accept_i,
  input wire core_return_i,
  input wire [`VIC_ADDR_W-1:0] pm_data_i,
  // request to core
  output reg irq_req_o,
  output reg [`VIC_VEC_W-1:0] irq_vec_o,
  output reg [`VIC_LVL_W-1:0] irq_lvl_o,
  // vector fetch
  output reg pm_rd_o,
  output reg [`VIC_ADDR_W-1:0] pm_addr_o,
  // handler hand-off
  output reg handler_valid_o,
  output reg [`VIC_ADDR_W-1:0] handler_addr_o,
  output reg [`VIC_VEC_W-1:0] taken_vec_o,
  output reg [`VIC_LVL_W-1:0] taken_lvl_o,
  output reg alt_used_o,
  output reg return_done_o,
  // status
  output reg busy_o,
  output reg [`VIC_NUM_TRAP-1:0] trap_pend_o
);

  reg [`VIC_ST_W-1:0] state;
  reg [`VIC_ST_W-1:0] next_state;
  reg [`VIC_CNT_W-1:0] cnt;
  reg [`VIC_CNT_W-1:0] next_cnt;
  reg [`VIC_NUM_TRAP-1:0] trap_pend;
  reg [`VIC_NUM_TRAP-1:0] trap_clr;

  wire win_valid;
  wire [`VIC_VEC_W-1:0] win_vec;
  wire [`VIC_LVL_W-1:0] win_lvl;
  wire use_alt;
  wire [`VIC_ADDR_W-1:0] entry_addr;
  wire take;
  wire win_beats_core;
  wire is_trap;
  wire entry_done;
  wire return_end;

  vic_arbiter u_arb (
    .irq_req_i(irq_req_i),
    .irq_en_i(irq_en_i),
    .irq_prio_i(irq_prio_i),
    .trap_pend_i(trap_pend),
    .win_valid_o(win_valid),
    .win_vec_o(win_vec),
    .win_lvl_o(win_lvl)
  );

  // address follows the presented vector so it is ready at the accept edge
  vic_vec_addr u_addr (
    .vec_i(irq_vec_o),
    .alt_sel_i(alt_table_select_i),
    .boot_seg_present_i(boot_seg_present_i),
    .boot_page_base_i(boot_page_base_i),
    .use_alt_o(use_alt),
    .entry_addr_o(entry_addr)
  );

  // a request is taken only while it stands and the sequencer is idle
  assign take = (state == `VIC_ST_IDLE) & irq_req_o & core_accept_i;
  // core level comparison done here so the core sees a filtered request
  assign win_beats_core = win_valid & (win_lvl > cpu_level_i);
  assign is_trap = (irq_vec_o < `VIC_IRQ_VEC0);
  assign entry_done = (state == `VIC_ST_ENTRY) & (cnt == `VIC_ENTRY_CYC);
  assign return_end = (state == `VIC_ST_RETURN) & (cnt == `VIC_RETURN_CYC);

  // only the trap that was actually taken is retired
  always @* begin
    trap_clr = `VIC_TRAP_NONE;
    if (take && is_trap) begin
      trap_clr = `VIC_TRAP_ONE << irq_vec_o[`VIC_TRAP_IDX_W-1:0];
    end
  end

  // sequencer with fixed counts so entry and return never vary
  always @* begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      `VIC_ST_IDLE: begin
        if (take) begin
          next_state = `VIC_ST_FETCH;
        end
      end
      `VIC_ST_FETCH: begin
        next_state = `VIC_ST_LOAD;
      end
      `VIC_ST_LOAD: begin
        next_state = `VIC_ST_ENTRY;
        next_cnt = `VIC_CNT_ZERO;
      end
      `VIC_ST_ENTRY: begin
        if (entry_done) begin
          next_state = `VIC_ST_SERVICE;
        end else begin
          next_cnt = cnt + `VIC_CNT_ONE;
        end
      end
      `VIC_ST_SERVICE: begin
        if (core_return_i) begin
          next_state = `VIC_ST_RETURN;
          next_cnt = `VIC_CNT_ZERO;
        end
      end
      `VIC_ST_RETURN: begin
        if (return_end) begin
          next_state = `VIC_ST_IDLE;
        end else begin
          next_cnt = cnt + `VIC_CNT_ONE;
        end
      end
      default: begin
        next_state = `VIC_ST_IDLE;
        next_cnt = `VIC_CNT_ZERO;
      end
    endcase
  end

  always @(posedge mclk_i) begin
    if (srst_i) begin
      state <= `VIC_ST_IDLE;
      cnt <= `VIC_CNT_ZERO;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // trap events are sticky; a new event in the clearing cycle survives
  always @(posedge mclk_i) begin
    if (srst_i) begin
      trap_pend <= `VIC_TRAP_NONE;
      trap_pend_o <= `VIC_TRAP_NONE;
    end else begin
      trap_pend <= (trap_pend & ~trap_clr) | trap_i;
      trap_pend_o <= (trap_pend & ~trap_clr) | trap_i;
    end
  end

  // presented request: one line plus vector and level, refreshed while idle
  always @(posedge mclk_i) begin
    if (srst_i) begin
      irq_req_o <= 1'b0;
      irq_vec_o <= `VIC_VEC_NONE;
      irq_lvl_o <= `VIC_LVL_OFF;
    end else if (state == `VIC_ST_IDLE && !take) begin
      irq_req_o <= win_beats_core;
      irq_vec_o <= win_vec;
      irq_lvl_o <= win_lvl;
    end else begin
      irq_req_o <= 1'b0;
    end
  end

  // vector entry read, one cycle wide, issued on the accept edge
  always @(posedge mclk_i) begin
    if (srst_i) begin
      pm_rd_o <= 1'b0;
      pm_addr_o <= `VIC_RESET_ADDR;
      alt_used_o <= 1'b0;
      taken_vec_o <= `VIC_VEC_NONE;
      taken_lvl_o <= `VIC_LVL_OFF;
    end else if (take) begin
      pm_rd_o <= 1'b1;
      pm_addr_o <= entry_addr;
      alt_used_o <= use_alt;
      taken_vec_o <= irq_vec_o;
      taken_lvl_o <= irq_lvl_o;
    end else begin
      pm_rd_o <= 1'b0;
    end
  end

  // handler address captured from the entry, released after the fixed count
  always @(posedge mclk_i) begin
    if (srst_i) begin
      handler_addr_o <= `VIC_RESET_ADDR;
      handler_valid_o <= 1'b0;
    end else begin
      if (state == `VIC_ST_LOAD) begin
        handler_addr_o <= pm_data_i;
      end
      handler_valid_o <= entry_done;
    end
  end

  // busy covers the whole take-to-return span; a new request waits for it
  always @(posedge mclk_i) begin
    if (srst_i) begin
      busy_o <= 1'b0;
      return_done_o <= 1'b0;
    end else begin
      return_done_o <= return_end;
      if (take) begin
        busy_o <= 1'b1;
      end else if (return_end) begin
        busy_o <= 1'b0;
      end
    end
  end

endmodule

// ### verif/vic_top_asserts.sv
// timing and address checks on the controller's ports
// assumes: bound to vic_top, sees only its ports
`timescale 1ns/1ns
module vic_top_asserts (
  // clock and reset
  input wire mclk_i,
  input wire srst_i,
  // watched inputs
  input wire [23:0] boot_page_base_i,
  input wire core_accept_i,
  input wire core_return_i,
  input wire [23:0] pm_data_i,
  // watched outputs
  input wire irq_req_o,
  input wire [6:0] irq_vec_o,
  input wire [3:0] irq_lvl_o,
  input wire pm_rd_o,
  input wire [23:0] pm_addr_o,
  input wire handler_valid_o,
  input wire [23:0] handler_addr_o,
  input wire [6:0] taken_vec_o,
  input wire alt_used_o,
  input wire return_done_o,
  input wire busy_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  // a return pulse outside service is ignored, so only count those after the hand-off
  reg in_svc;
  always @(posedge mclk_i)
    if (srst_i || return_done_o) in_svc <= 1'b0;
    else if (handler_valid_o) in_svc <= 1'b1;
  a_take_fetch: assert property (irq_req_o && core_accept_i && !busy_o |=> pm_rd_o && busy_o && !irq_req_o)
    else $error("take did not start fetch");
  a_busy_quiet: assert property (busy_o |-> !irq_req_o)
    else $error("request while busy");
  a_pri_addr: assert property (pm_rd_o && !alt_used_o |-> pm_addr_o == 24'h000004 + {taken_vec_o, 1'b0})
    else $error("primary entry address wrong");
  a_alt_addr: assert property (pm_rd_o && alt_used_o |->
    pm_addr_o == $past(boot_page_base_i) + 24'h000004 + {taken_vec_o, 1'b0})
    else $error("alternate entry address wrong");
  a_entry_lat: assert property (pm_rd_o |-> ##8 handler_valid_o)
    else $error("entry latency wrong");
  a_handler_data: assert property (handler_valid_o |-> handler_addr_o == $past(pm_data_i, 7))
    else $error("handler address not the fetched entry");
  a_return_lat: assert property (core_return_i && in_svc |-> ##5 return_done_o && !busy_o)
    else $error("return latency wrong");
  a_trap_lvl: assert property (irq_req_o && irq_vec_o < 7'h08 |-> irq_lvl_o == 4'hf - irq_vec_o[3:0])
    else $error("trap level wrong");
endmodule

// ### verif/vic_core_model.sv
// core stand-in: takes requests, serves entry reads, returns from handlers
// assumes: entry data wanted one cycle after the read strobe
`timescale 1ns/1ns
module vic_core_model (
  // clock and reset
  input wire mclk_i,
  input wire srst_i,
  // behaviour
  input wire slow_i,
  // controller side
  input wire req_i,
  input wire rd_i,
  input wire [23:0] addr_i,
  input wire hv_i,
  output reg accept_o,
  output reg ret_o,
  output reg [23:0] data_o
);
  reg [2:0] wait_cnt;
  reg [1:0] ret_cnt;
  always @(posedge mclk_i) begin
    if (srst_i) begin
      accept_o <= 1'b0;
      ret_o <= 1'b0;
      wait_cnt <= 3'h0;
      ret_cnt <= 2'h0;
      data_o <= 24'h000000;
    end else begin
      wait_cnt <= req_i ? wait_cnt + 3'h1 : 3'h0;
      // a slow core lets the request stand, so a higher one may overtake it
      accept_o <= req_i && !accept_o && (!slow_i || wait_cnt == 3'h6);
      // every entry holds a handler; off the strobe the bus toggles
      data_o <= rd_i ? addr_i ^ 24'h5a5a5a : ~data_o;
      ret_o <= ret_cnt == 2'h1;
      if (hv_i) ret_cnt <= 2'h3;
      else if (ret_cnt != 2'h0) ret_cnt <= ret_cnt - 2'h1;
    end
  end
endmodule

// ### verif/vectored_interrupt_controller_test.sv
// self-checking bench for the vectored interrupt controller
// assumes: vic_top, the core model and the checker compile with it
`timescale 1ns/1ns
module vectored_interrupt_controller_test;
  reg mclk_i = 1'b0, srst_i = 1'b1, alt_table_select_i = 1'b0, boot_seg_present_i = 1'b0, slow = 1'b0;
  reg [117:0] irq_req_i = 118'h0, irq_en_i = 118'h0;
  reg [353:0] irq_prio_i = 354'h0;
  reg [7:0] trap_i = 8'h00;
  reg [23:0] boot_page_base_i = 24'h000000;
  reg [3:0] cpu_level_i = 4'h0;
  wire core_accept_i, core_return_i, irq_req_o, pm_rd_o, handler_valid_o, alt_used_o, return_done_o, busy_o;
  wire [23:0] pm_data_i, pm_addr_o, handler_addr_o;
  wire [6:0] irq_vec_o, taken_vec_o;
  wire [3:0] irq_lvl_o, taken_lvl_o;
  wire [7:0] trap_pend_o;
  reg [35:0] exp_q[$];
  reg [31:0] seed = 32'h2448eb40;
  integer n_fail = 0, checks = 0, v, k1, k2, l1, l2, w;
  always #5 mclk_i = ~mclk_i;
  vic_top i_dut (.*);
  vic_core_model i_core (.mclk_i, .srst_i, .slow_i(slow), .req_i(irq_req_o), .rd_i(pm_rd_o), .addr_i(pm_addr_o),
    .hv_i(handler_valid_o), .accept_o(core_accept_i), .ret_o(core_return_i), .data_o(pm_data_i));
  function [31:0] xs(input [31:0] x);
    begin
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
    end
  endfunction
  task summarize;
    begin
      if (n_fail == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  task fail(input [63:0] what, input [63:0] e, input [63:0] g);
    begin
      $display("[FAIL] %0s exp %h got %h", what, e, g);
      n_fail = n_fail + 1;
    end
  endtask
  // sampled mid-cycle, away from the edge that launches the pulse
  always @(negedge mclk_i)
    if (handler_valid_o) begin
      checks = checks + 1;
      if (exp_q.size() == 0 || {alt_used_o, taken_vec_o, taken_lvl_o, handler_addr_o} !== exp_q[0])
        fail("handler", exp_q.size() ? exp_q[0] : 36'h0, {alt_used_o, taken_vec_o, taken_lvl_o, handler_addr_o});
      if (exp_q.size() != 0) exp_q.delete(0);
    end
  task wt(input s);
    integer i;
    begin
      for (i = 0; i < 300 && (s ? !return_done_o : !handler_valid_o); i = i + 1) @(negedge mclk_i);
      if (i == 300) begin
        fail("timeout", 0, s);
        summarize;
      end
    end
  endtask
  task src(input integer k, input integer l, input e);
    begin
      irq_req_i[k] = 1'b1;
      irq_en_i[k] = e;
      irq_prio_i[3*k +: 3] = l;
    end
  endtask
  // peripherals drop their request once the handler is entered
  task serve(input integer vec, input alt);
    reg [23:0] a;
    reg [3:0] l;
    begin
      a = (alt ? boot_page_base_i : 24'h000000) + 24'h000004 + 2 * vec;
      if (vec < 8) l = 4'hf - vec;
      else l = irq_prio_i[3*(vec-8) +: 3];
      exp_q.push_back({alt, vec[6:0], l, a ^ 24'h5a5a5a});
      wt(1'b0);
      if (vec >= 8) irq_req_i[vec-8] = 1'b0;
      wt(1'b1);
    end
  endtask
  initial begin
    repeat (8) @(negedge mclk_i);
    srst_i = 1'b0;
    trap_i = 8'hff;
    @(negedge mclk_i);
    trap_i = 8'h00;
    checks = checks + 1;
    if (trap_pend_o !== 8'hff) fail("trap", 8'hff, trap_pend_o);
    src(50, 7, 1);
    for (v = 0; v < 8; v = v + 1) serve(v, 0);
    serve(58, 0);
    src(5, 3, 1);
    src(0, 3, 1);
    src(100, 6, 1);
    src(117, 7, 0);
    serve(108, 0);
    serve(8, 0);
    serve(13, 0);
    src(117, 1, 1);
    serve(125, 0);
    cpu_level_i = 4'h5;
    src(3, 5, 1);
    repeat (20) @(negedge mclk_i);
    checks = checks + 1;
    if (irq_req_o !== 1'b0) fail("request", 0, irq_req_o);
    cpu_level_i = 4'h4;
    serve(11, 0);
    cpu_level_i = 4'h0;
    alt_table_select_i = 1'b1;
    src(1, 2, 1);
    serve(9, 0);
    boot_seg_present_i = 1'b1;
    boot_page_base_i = 24'h012300;
    trap_i = 8'h10;
    @(negedge mclk_i);
    trap_i = 8'h00;
    serve(4, 1);
    for (v = 0; v < 24; v = v + 1) begin
      seed = xs(seed);
      k1 = seed[6:0] % 118;
      k2 = (k1 + 1 + seed[13:8]) % 118;
      l1 = seed[18:16] % 7 + 1;
      l2 = seed[21:19] % 7 + 1;
      slow = seed[22];
      alt_table_select_i = seed[23];
      boot_page_base_i = {seed[31:24], 16'h0000};
      src(k1, l1, 1);
      src(k2, l2, 1);
      w = (l1 > l2 || (l1 == l2 && k1 < k2)) ? k1 : k2;
      serve(w + 8, seed[23]);
      serve(k1 + k2 - w + 8, seed[23]);
    end
    srst_i = 1'b1;
    src(7, 4, 1);
    repeat (2) @(negedge mclk_i);
    checks = checks + 1;
    if ({irq_req_o, busy_o, pm_addr_o, handler_addr_o} !== 50'h0)
      fail("reset", 0, {irq_req_o, busy_o, pm_addr_o, handler_addr_o});
    srst_i = 1'b0;
    serve(15, alt_table_select_i);
    summarize;
  end
endmodule
bind vic_top vic_top_asserts u_chk (.*);
